// >>> aah_params.svh
`ifndef AAH_PARAMS_SVH
`define AAH_PARAMS_SVH
`define AAH_CLK_HZ        10000000
`define AAH_MS_CYC        (`AAH_CLK_HZ / 1000)
`define AAH_FRAME_MS      4
`define AAH_HIST_DEPTH    64
`define AAH_POST_FRAMES   24
`define AAH_LOG_DEPTH     128
`define AAH_STATUS_MS     2000
`define AAH_HOLD_MS       5000
`define AAH_RATED_MS      120000
`define AAH_CALC_MS       6000
`define AAH_BLINK_MS      250
`define AAH_DC_PCT        90
`define AAH_NALARM        16
`define AAH_TRIG_MASK     16'h07ff
`define AAH_CONV_MASK     16'h1800
`define AAH_BYP_BIT       0
`endif

// >>> aah_pkg.sv
package aah_pkg;
   typedef struct packed
   {
      logic [15:0] alarms;
      logic [15:0] volts;
      logic [15:0] amps;
      logic [15:0] frame_no;
      logic [31:0] stamp_ms;
   } aah_frame_type;
   typedef enum logic [1:0] {HS_RUN, HS_POST, HS_FROZEN} aah_hist_type;
endpackage

// >>> aah_annunciator.sv
`timescale 1ns/1ps
`include "aah_params.svh"
module aah_annunciator
#(
   parameter int HIST_DEPTH = `AAH_HIST_DEPTH,
   parameter int LOG_DEPTH  = `AAH_LOG_DEPTH,
   parameter int MS_CYC     = `AAH_MS_CYC,
   parameter int HOLD_MS    = `AAH_HOLD_MS,
   parameter int RATED_MS   = `AAH_RATED_MS,
   parameter int CALC_MS    = `AAH_CALC_MS
)
(
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  NRST,
   // Plant inputs
   input  wire logic [15:0]           ALARM_IN,
   input  wire logic [15:0]           VOLTS_IN,
   input  wire logic [15:0]           AMPS_IN,
   input  wire logic [6:0]            DC_BUS_PCT,
   input  wire logic                  LOAD_ON_CONV,
   input  wire logic                  SW_CONNECTED,
   input  wire logic                  XFER_OK,
   input  wire logic                  DISCHARGING,
   input  wire logic [15:0]           RATED_MIN,
   input  wire logic [15:0]           CALC_MIN,
   // Operator controls
   input  wire logic                  HORN_OFF,
   input  wire logic                  ALARM_RESET,
   input  wire logic                  DISPLAY_CLEAR,
   // Readback
   input  wire logic [5:0]            HIST_IDX,
   input  wire logic [6:0]            LOG_IDX,
   output aah_pkg::aah_frame_type     HIST_DATA,
   output aah_pkg::aah_frame_type     LOG_DATA,
   output aah_pkg::aah_frame_type     STATUS_VIEW,
   // Indications
   output logic [15:0]                ALARM_SHOW,
   output logic                       HORN,
   output logic                       FROZEN,
   output logic                       INV_EN,
   output logic                       SW_CONN_IND,
   output logic                       XFER_OK_IND,
   output logic [15:0]                TIME_LEFT,
   output logic                       TIME_CALC
);
   // The readback index widths fix both depths; the counter widths below
   // bound the timing counts.
   if (HIST_DEPTH != 64 || LOG_DEPTH != 128 ||
       MS_CYC < 2 || MS_CYC > 65536 || HOLD_MS < 1 || HOLD_MS > 8190 ||
       RATED_MS < 1 || RATED_MS > 131071 || CALC_MS < 1 || CALC_MS > 8192)
      $error("aah_annunciator: unsupported parameters");

   typedef struct packed
   {
      logic [15:0] cyc;
      logic [31:0] ms;
      logic [1:0]  sub;
      logic [15:0] frame_no;
      logic [15:0] volts;
      logic [15:0] amps;
      logic [15:0] frame_alm;
      logic [15:0] latched;
      logic [15:0] prev_alm;
      logic        silenced;
      logic [8:0]  blink;
      logic        blink_on;
      aah_pkg::aah_hist_type hst;
      logic [5:0]  wr_ptr;
      logic [4:0]  post;
      logic [6:0]  log_ptr;
      logic [12:0] hold;
      logic [10:0] stat_ms;
      aah_pkg::aah_frame_type status;
      logic [16:0] dis_ms;
      logic [12:0] calc_ms;
      logic [15:0] time_left;
      logic        inv_en;
   } aah_state_type;

   aah_state_type st_reg;
   aah_state_type st_next;
   aah_pkg::aah_frame_type hist_mem [HIST_DEPTH];
   aah_pkg::aah_frame_type log_mem  [LOG_DEPTH];
   logic [1:0] sync_reg;
   logic rst_n;
   logic ms_tick;
   logic frame_tick;
   logic fault_now;
   logic store_hist;
   logic store_log;
   aah_pkg::aah_frame_type frame_word;

   //////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         sync_reg <= 2'h0;
      else
         sync_reg <= {sync_reg[0], 1'b1};
   end
   assign rst_n = sync_reg[1];

   //////////////////////////////////////////////////////////////////////////
   assign ms_tick    = (st_reg.cyc == 16'(MS_CYC - 1));
   assign frame_tick = ms_tick && (st_reg.sub == 2'(`AAH_FRAME_MS - 1));
   // Converter-path alarms only count while the load is on the converter.
   assign fault_now  = |(ALARM_IN & 16'(`AAH_TRIG_MASK)) ||
                       (LOAD_ON_CONV && |(ALARM_IN & 16'(`AAH_CONV_MASK)));
   assign frame_word = '{alarms: st_reg.frame_alm | ALARM_IN,
                         volts: st_reg.volts, amps: st_reg.amps,
                         frame_no: st_reg.frame_no, stamp_ms: st_reg.ms};
   assign store_hist = frame_tick && (st_reg.hst != aah_pkg::HS_FROZEN);
   assign store_log  = frame_tick && (|frame_word.alarms);

   always_comb
   begin
      st_next = st_reg;
      st_next.cyc = ms_tick ? 16'h0 : st_reg.cyc + 16'h1;
      if (ms_tick)
      begin
         st_next.ms    = st_reg.ms + 32'h1;
         st_next.sub   = (st_reg.sub == 2'(`AAH_FRAME_MS - 1)) ? 2'h0
                                                                : st_reg.sub + 2'h1;
         st_next.volts = VOLTS_IN;
         st_next.amps  = AMPS_IN;
      end
      // Alarms seen within a frame accumulate to clock-cycle resolution.
      st_next.frame_alm = frame_tick ? 16'h0 : st_reg.frame_alm | ALARM_IN;
      if (frame_tick)
         st_next.frame_no = st_reg.frame_no + 16'h1;
      // A new alarm re-arms the blink; horn silence stops it.
      st_next.prev_alm = ALARM_IN;
      if (HORN_OFF)
         st_next.silenced = 1'b1;
      else if (|(ALARM_IN & ~st_reg.prev_alm))
         st_next.silenced = 1'b0;
      st_next.latched = st_reg.latched | ALARM_IN;
      if (ALARM_RESET && st_reg.silenced)
         st_next.latched = ALARM_IN;
      if (ms_tick)
      begin
         st_next.blink = (st_reg.blink == 9'(`AAH_BLINK_MS - 1)) ? 9'h0
                                                          : st_reg.blink + 9'h1;
         if (st_reg.blink == 9'(`AAH_BLINK_MS - 1))
            st_next.blink_on = ~st_reg.blink_on;
      end
      // Long reset hold, counted in milliseconds.
      if (!ALARM_RESET)
         st_next.hold = 13'h0;
      else if (ms_tick && st_reg.hold <= 13'(HOLD_MS))
         st_next.hold = st_reg.hold + 13'h1;
      if (store_hist)
         st_next.wr_ptr = st_reg.wr_ptr + 6'h1;
      if (store_log)
         st_next.log_ptr = st_reg.log_ptr + 7'h1;
      unique case (st_reg.hst)
         aah_pkg::HS_RUN:
            if (frame_tick && fault_now)
            begin
               st_next.hst  = aah_pkg::HS_POST;
               st_next.post = 5'(`AAH_POST_FRAMES - 1);
            end
         aah_pkg::HS_POST:
            if (frame_tick)
            begin
               st_next.post = st_reg.post - 5'h1;
               if (st_reg.post == 5'h1)
                  st_next.hst = aah_pkg::HS_FROZEN;
            end
         aah_pkg::HS_FROZEN:
            if (!fault_now && (DISPLAY_CLEAR ||
                st_reg.hold > 13'(HOLD_MS)))
            begin
               st_next.hst  = aah_pkg::HS_RUN;
               st_next.post = 5'h0;
            end
      endcase
      if (ms_tick)
         st_next.stat_ms = (st_reg.stat_ms == 11'(`AAH_STATUS_MS - 1)) ? 11'h0
                                                       : st_reg.stat_ms + 11'h1;
      if (ms_tick && st_reg.stat_ms == 11'(`AAH_STATUS_MS - 1))
         st_next.status = frame_word;
      // Rated figure for the opening minutes, then the calculated one.
      if (!DISCHARGING)
      begin
         st_next.dis_ms    = 17'h0;
         st_next.calc_ms   = 13'h0;
         st_next.time_left = 16'h0;
      end
      else if (st_reg.dis_ms < 17'(RATED_MS))
      begin
         st_next.time_left = RATED_MIN;
         if (ms_tick)
            st_next.dis_ms = st_reg.dis_ms + 17'h1;
      end
      else if (ms_tick)
      begin
         st_next.calc_ms = (st_reg.calc_ms == 13'(CALC_MS - 1)) ? 13'h0
                                                      : st_reg.calc_ms + 13'h1;
         if (st_reg.calc_ms == 13'h0)
            st_next.time_left = CALC_MIN;
      end
      if (DC_BUS_PCT >= 7'(`AAH_DC_PCT))
         st_next.inv_en = 1'b1;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.cyc       <= 16'h0;
         st_reg.ms        <= 32'h0;
         st_reg.sub       <= 2'h0;
         st_reg.frame_no  <= 16'h0;
         st_reg.volts     <= 16'h0;
         st_reg.amps      <= 16'h0;
         st_reg.frame_alm <= 16'h0;
         st_reg.latched   <= 16'h0;
         st_reg.prev_alm  <= 16'h0;
         st_reg.silenced  <= 1'b1;
         st_reg.blink     <= 9'h0;
         st_reg.blink_on  <= 1'b0;
         st_reg.hst       <= aah_pkg::HS_RUN;
         st_reg.wr_ptr    <= 6'h0;
         st_reg.post      <= 5'h0;
         st_reg.log_ptr   <= 7'h0;
         st_reg.hold      <= 13'h0;
         st_reg.stat_ms   <= 11'h0;
         st_reg.status    <= '0;
         st_reg.dis_ms    <= 17'h0;
         st_reg.calc_ms   <= 13'h0;
         st_reg.time_left <= 16'h0;
         st_reg.inv_en    <= 1'b0;
      end
      else
      begin
         st_reg.cyc       <= st_next.cyc;
         st_reg.ms        <= st_next.ms;
         st_reg.sub       <= st_next.sub;
         st_reg.frame_no  <= st_next.frame_no;
         st_reg.volts     <= st_next.volts;
         st_reg.amps      <= st_next.amps;
         st_reg.frame_alm <= st_next.frame_alm;
         st_reg.latched   <= st_next.latched;
         st_reg.prev_alm  <= st_next.prev_alm;
         st_reg.silenced  <= st_next.silenced;
         st_reg.blink     <= st_next.blink;
         st_reg.blink_on  <= st_next.blink_on;
         st_reg.hst       <= st_next.hst;
         st_reg.wr_ptr    <= st_next.wr_ptr;
         st_reg.post      <= st_next.post;
         st_reg.log_ptr   <= st_next.log_ptr;
         st_reg.hold      <= st_next.hold;
         st_reg.stat_ms   <= st_next.stat_ms;
         st_reg.status    <= st_next.status;
         st_reg.dis_ms    <= st_next.dis_ms;
         st_reg.calc_ms   <= st_next.calc_ms;
         st_reg.time_left <= st_next.time_left;
         st_reg.inv_en    <= st_next.inv_en;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Memories carry no reset; readback before first write is undefined.
   always_ff @(posedge CLK)
   begin
      if (store_hist)
         hist_mem[st_reg.wr_ptr] <= frame_word;
      if (store_log)
         log_mem[st_reg.log_ptr] <= frame_word;
      HIST_DATA <= hist_mem[6'(st_reg.wr_ptr + HIST_IDX)];
      LOG_DATA  <= log_mem[7'(st_reg.log_ptr + LOG_IDX)];
      ALARM_SHOW <= (st_reg.silenced || st_reg.blink_on) ? st_reg.latched
                                                           : 16'h0;
      SW_CONN_IND <= SW_CONNECTED;
      XFER_OK_IND <= XFER_OK;
   end

   assign STATUS_VIEW = st_reg.status;
   assign HORN        = |st_reg.latched && !st_reg.silenced;
   assign FROZEN      = (st_reg.hst == aah_pkg::HS_FROZEN);
   assign INV_EN      = st_reg.inv_en;
   assign TIME_LEFT   = st_reg.time_left;
   assign TIME_CALC   = (st_reg.dis_ms >= 17'(RATED_MS));

   //////////////////////////////////////////////////////////////////////////
   sequence s_fault_frame;
      frame_tick && fault_now && st_reg.hst == aah_pkg::HS_RUN;
   endsequence
   a_post_enter: assert property (@(posedge CLK) disable iff (!rst_n)
      s_fault_frame |=> st_reg.hst == aah_pkg::HS_POST)
      else $error("capture did not start");
   a_freeze_stop: assert property (@(posedge CLK) disable iff (!rst_n)
      FROZEN |-> !store_hist ##1 $stable(st_reg.wr_ptr))
      else $error("frozen history written");
   a_frame_count: assert property (@(posedge CLK) disable iff (!rst_n)
      frame_tick |=> st_reg.frame_no == $past(st_reg.frame_no) + 16'h1)
      else $error("frame number not advanced");
   a_inv_gate: assert property (@(posedge CLK) disable iff (!rst_n)
      $rose(INV_EN) |-> $past(DC_BUS_PCT) >= 7'(`AAH_DC_PCT))
      else $error("inverter enabled early");
   a_latch_hold: assert property (@(posedge CLK) disable iff (!rst_n)
      !ALARM_RESET |=> ($past(st_reg.latched) & ~st_reg.latched) == 16'h0)
      else $error("latched alarm dropped");
   a_horn_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
      HORN_OFF |=> !HORN)
      else $error("horn still sounding");
   a_resume_cond: assert property (@(posedge CLK) disable iff (!rst_n)
      FROZEN ##1 !FROZEN |-> !$past(fault_now))
      else $error("resumed with fault present");
   a_rearm_clear: assert property (@(posedge CLK) disable iff (!rst_n)
      FROZEN ##1 !FROZEN |->
         st_reg.hst == aah_pkg::HS_RUN && st_reg.post == 5'h0)
      else $error("post counter not restarted");
endmodule

// >>> aah_panel.sv
`timescale 1ns/1ps
module aah_panel
(
   // Clock
   input  wire logic clk,
   // Operator pads
   output logic      horn_off,
   output logic      alarm_reset,
   output logic      display_clear
);
   //////////////////////////////////////////////////////////////
   // Pads idle low; a press is a level held for whole clock cycles.
   initial
   begin
      horn_off = 1'b0;
      alarm_reset = 1'b0;
      display_clear = 1'b0;
   end
   task automatic silence(input int n);
      @(posedge clk);
      horn_off <= 1'b1;
      repeat (n) @(posedge clk);
      horn_off <= 1'b0;
   endtask
   // The hold length decides whether a frozen history may resume.
   task automatic reset_hold(input int n);
      @(posedge clk);
      alarm_reset <= 1'b1;
      repeat (n) @(posedge clk);
      alarm_reset <= 1'b0;
   endtask
   task automatic clear_display;
      @(posedge clk);
      display_clear <= 1'b1;
      @(posedge clk);
      display_clear <= 1'b0;
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int MS = 4;
   localparam int FR = 4 * MS;
   localparam int HOLD = 3;
   localparam int RATED = 8;
   localparam int CALC = 3;
   localparam int LIMIT = 40000;
   logic                  clk, nrst, load_on_conv, sw_connected;
   logic                  xfer_ok, discharging, horn_off, alarm_reset;
   logic                  display_clear, horn, frozen, inv_en;
   logic                  sw_conn_ind, xfer_ok_ind, time_calc;
   logic [15:0]           alarm_in, volts_in, amps_in, rated_min;
   logic [15:0]           calc_min, alarm_show, time_left;
   logic [6:0]            dc_bus_pct, log_idx;
   logic [5:0]            hist_idx;
   aah_pkg::aah_frame_type hist_data, log_data, status_view, f0, f1, l0;
   int                    miscompares, tests_run, cycles;
   //////////////////////////////////////////////////////////////
   aah_annunciator #(.MS_CYC(MS), .HOLD_MS(HOLD), .RATED_MS(RATED),
                     .CALC_MS(CALC)) uut
   (
      .CLK(clk), .NRST(nrst), .ALARM_IN(alarm_in), .VOLTS_IN(volts_in),
      .AMPS_IN(amps_in), .DC_BUS_PCT(dc_bus_pct),
      .LOAD_ON_CONV(load_on_conv), .SW_CONNECTED(sw_connected),
      .XFER_OK(xfer_ok), .DISCHARGING(discharging),
      .RATED_MIN(rated_min), .CALC_MIN(calc_min), .HORN_OFF(horn_off),
      .ALARM_RESET(alarm_reset), .DISPLAY_CLEAR(display_clear),
      .HIST_IDX(hist_idx), .LOG_IDX(log_idx), .HIST_DATA(hist_data),
      .LOG_DATA(log_data), .STATUS_VIEW(status_view),
      .ALARM_SHOW(alarm_show), .HORN(horn), .FROZEN(frozen),
      .INV_EN(inv_en), .SW_CONN_IND(sw_conn_ind),
      .XFER_OK_IND(xfer_ok_ind), .TIME_LEFT(time_left),
      .TIME_CALC(time_calc)
   );
   aah_panel panel
   (
      .clk(clk), .horn_off(horn_off), .alarm_reset(alarm_reset),
      .display_clear(display_clear)
   );
   //////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Outputs read at the edge are the values settled before it, and
   // stimulus given here is first sampled on the edge after it.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic set_alarm(input logic [15:0] v);
      @(posedge clk);
      alarm_in <= v;
   endtask
   task automatic rd(input int i);
      @(posedge clk);
      hist_idx <= 6'(i);
      log_idx <= 7'(i);
      tick(2);
   endtask
   // Only a freeze before 20 frames or after 26 frames from the alarm shows up here.
   task automatic capture(input logic [15:0] v);
      set_alarm(v);
      tick(20 * FR);
      chk(frozen, 1'b0);
      for (int i = 0; i < 6 * FR && frozen !== 1'b1; i++)
         tick(1);
      chk(frozen, 1'b1);
      set_alarm(16'h0000);
   endtask
   task automatic wait_view(output aah_pkg::aah_frame_type f);
      f = status_view;
      for (int i = 0; i < 9000 && status_view === f; i++)
         tick(1);
      f = status_view;
   endtask
   //////////////////////////////////////////////////////////////
   task automatic t_plant;
      @(posedge clk);
      dc_bus_pct <= 7'd89;
      tick(4);
      chk(inv_en, 1'b0);
      dc_bus_pct <= 7'd90;
      tick(4);
      chk(inv_en, 1'b1);
      for (int v = 0; v < 4; v++)
      begin
         sw_connected <= v[0];
         xfer_ok <= v[1];
         tick(3);
         chk({sw_conn_ind, xfer_ok_ind}, {v[0], v[1]});
      end
      rated_min <= 16'h0123;
      calc_min <= 16'h0456;
      discharging <= 1'b1;
      tick(4);
      chk({time_calc, time_left}, 17'h00123);
      tick(RATED * MS - 3 * MS);
      chk({time_calc, time_left}, 17'h00123);
      tick(5 * MS);
      chk({time_calc, time_left}, 17'h10456);
      calc_min <= 16'h0789;
      tick(5 * MS);
      chk({time_calc, time_left}, 17'h10789);
      discharging <= 1'b0;
   endtask
   task automatic t_latch;
      int on_n;
      int off_n;
      on_n = 0;
      off_n = 0;
      set_alarm(16'h2000);
      tick(2 * FR);
      for (int i = 0; i < 2500; i++)
      begin
         tick(1);
         if (alarm_show[13] === 1'b1) on_n++;
         if (alarm_show[13] === 1'b0) off_n++;
      end
      // The alarm stays up through the blink watch so the event log wraps.
      set_alarm(16'h0000);
      chk(on_n > 0 && off_n > 0, 1'b1);
      panel.reset_hold(3);
      tick(3);
      chk(horn, 1'b1);
      panel.silence(3);
      tick(3);
      chk({horn, alarm_show}, 17'h02000);
      panel.reset_hold(3);
      tick(3);
      chk(alarm_show, 16'h0000);
   endtask
   task automatic t_history;
      tick(66 * FR);
      capture(16'h0008);
      rd(40);
      f1 = hist_data;
      rd(39);
      f0 = hist_data;
      chk({f1.alarms[3], f0.alarms[3]}, 2'b10);
      chk(16'(f1.frame_no - f0.frame_no), 16'h0001);
      chk(32'(f1.stamp_ms - f0.stamp_ms), 32'h4);
      chk({f1.volts, f1.amps}, 32'h1234_0042);
      rd(63);
      f1 = hist_data;
      rd(0);
      chk(16'(f1.frame_no - hist_data.frame_no), 16'h003f);
      l0 = log_data;
      chk(l0.alarms[13], 1'b1);
      rd(1);
      chk(log_data.stamp_ms > l0.stamp_ms, 1'b1);
      tick(4 * FR);
      rd(63);
      chk(hist_data.frame_no, f1.frame_no);
      panel.silence(2);
      panel.reset_hold(HOLD * MS / 2);
      tick(3);
      chk(frozen, 1'b1);
      panel.reset_hold(HOLD * MS + 8);
      tick(3);
      chk(frozen, 1'b0);
   endtask
   task automatic t_conv;
      load_on_conv <= 1'b0;
      set_alarm(16'h0800);
      tick(30 * FR);
      chk(frozen, 1'b0);
      set_alarm(16'h0000);
      tick(2 * FR);
      load_on_conv <= 1'b1;
      capture(16'h1000);
      panel.clear_display();
      tick(3);
      chk(frozen, 1'b0);
   endtask
   task automatic t_view;
      wait_view(f0);
      wait_view(f1);
      chk(16'(f1.frame_no - f0.frame_no), 16'd500);
      chk(32'(f1.stamp_ms - f0.stamp_ms), 32'd2000);
   endtask
   //////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   initial
   begin
      {nrst, load_on_conv, sw_connected, xfer_ok, discharging} = '0;
      {alarm_in, rated_min, calc_min, hist_idx, log_idx} = '0;
      {volts_in, amps_in, dc_bus_pct} = {16'h1234, 16'h0042, 7'd0};
      {miscompares, tests_run, cycles} = '0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(4);
      t_plant();
      t_latch();
      t_history();
      t_conv();
      t_view();
      report_and_stop();
   end
endmodule
